// ===== design/cic_arbiter.sv
/*
 * One fixed-priority request arbiter of eight levels, level 0 highest.
 * Assumes requests are already synchronised to clock, and that ack
 * and eoi are one-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ns
`include "cic_consts.svh"
module cic_arbiter
	import cic_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] req_in,
	input wire logic ack,
	input wire logic eoi,
	output logic int_out,
	output logic [2:0] win_level,
	output logic win_valid
);

	cic_arb_state_s st_r; // Registered state
	cic_arb_state_s st_nxt; // Next state
	logic [7:0] rise; // Rising request edges
	logic [3:0] irr_top; // Best pending level
	logic [3:0] isr_top; // Best level in service
	logic [3:0] nirr_top; // Best pending level next cycle
	logic [3:0] nisr_top; // Best in-service level next cycle
	logic [7:0] isr_after_eoi; // In-service bits once eoi is applied

	////////////////////////////////////////////////////////////////////
	// Priority resolution against what is already in service
	always_comb begin
		rise = req_in & ~st_r.prev;
		irr_top = cic_lowest(st_r.irr);
		isr_top = cic_lowest(st_r.isr);
		// A pending level wins only above every level in service
		win_valid = (irr_top < isr_top);
		win_level = win_valid ? irr_top[2:0] : `CIC_SPURIOUS_LEVEL;
	end

	////////////////////////////////////////////////////////////////////
	// Next state: edge capture, acknowledge, end of interrupt
	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = req_in;
		// Request must stay high until acknowledged, else it is dropped
		st_nxt.irr = (st_r.irr | rise) & req_in;
		isr_after_eoi = st_r.isr;
		if (eoi && !isr_top[3]) begin
			// Non-specific end clears the best level in service
			isr_after_eoi[isr_top[2:0]] = 1'b0;
		end
		st_nxt.isr = isr_after_eoi;
		if (ack && win_valid) begin
			// A new edge on the same level wins over the clear
			st_nxt.isr[win_level] = 1'b1;
			st_nxt.irr[win_level] = rise[win_level];
		end
		// Request out is judged on the state it will hold
		nirr_top = cic_lowest(st_nxt.irr);
		nisr_top = cic_lowest(st_nxt.isr);
		st_nxt.int_r = (nirr_top < nisr_top);
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign int_out = st_r.int_r;

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_ack_in_service;
		@(posedge clock) disable iff (!rst_n)
		(ack && win_valid) |=> st_r.isr[$past(win_level)];
	endproperty
	a_ack_in_service: assert property (p_ack_in_service)
		else $error("acknowledged level not in service");

	property p_int_needs_pending;
		@(posedge clock) disable iff (!rst_n)
		int_out |-> (cic_lowest(st_r.irr) < cic_lowest(st_r.isr));
	endproperty
	a_int_needs_pending: assert property (p_int_needs_pending)
		else $error("request out without a winning pending level");

	property p_edge_raises;
		@(posedge clock) disable iff (!rst_n)
		(rise[0] && !ack && st_r.isr[0] == 1'b0) |=> int_out;
	endproperty
	a_edge_raises: assert property (p_edge_raises)
		else $error("level 0 edge did not raise request");

endmodule

// ===== design/cic_consts.svh
/*
 * Constants of the cascaded interrupt controller: level numbers,
 * vector bases, pin count and pin positions.
 * Assumes it is included by bare name wherever the values are needed.
 */
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH

// Vector bases of the two controllers (plain defaults, overridable)
`define CIC_PRI_VEC_BASE 8'h08
`define CIC_SEC_VEC_BASE 8'h70

// Cascade level on the primary and the level reported when nothing wins
`define CIC_CASCADE_LEVEL 3'h2
`define CIC_SPURIOUS_LEVEL 3'h7

// Number of synchronised input pins and their positions
`define CIC_NPIN 14
`define CIC_PIN_TIMER 0
`define CIC_PIN_KBD 1
`define CIC_PIN_SER_A 2
`define CIC_PIN_SER_B 3
`define CIC_PIN_FLOPPY 4
`define CIC_PIN_LPT1 5
`define CIC_PIN_RTC 6
`define CIC_PIN_LAN 7
`define CIC_PIN_SPARE11 8
`define CIC_PIN_MOUSE 9
`define CIC_PIN_FPU 10
`define CIC_PIN_HD0 11
`define CIC_PIN_HD1 12
`define CIC_PIN_SWAP 13

`endif

// ===== design/cic_controller.sv
/*
 * Cascaded interrupt controller: a primary and a secondary arbiter,
 * pin synchronisers, level routing and the vector answer.
 * Assumes request pins are asynchronous, while intr_ack and the two
 * end-of-interrupt pulses come from processor logic on clock.
 */
`timescale 1ns/1ns
`include "cic_consts.svh"
module cic_controller
	import cic_pkg::*;
#(
	parameter logic [7:0] PRI_VEC_BASE = `CIC_PRI_VEC_BASE,
	parameter logic [7:0] SEC_VEC_BASE = `CIC_SEC_VEC_BASE
)(
	input wire logic clock,
	input wire logic rst_n,
	input cic_irq_pins_s irq_pins,
	input wire logic serial_swap,
	input wire logic intr_ack,
	input wire logic eoi_primary,
	input wire logic eoi_secondary,
	output logic int_req,
	output cic_vec_s vec_out
);

	cic_top_state_s st_r; // Registered state
	cic_top_state_s st_nxt; // Next state
	logic [`CIC_NPIN-1:0] pin_raw; // Pins packed by position
	logic [7:0] pri_req; // Primary request levels
	logic [7:0] sec_req; // Secondary request levels
	logic sec_int; // Secondary combined request
	logic pri_int; // Primary combined request
	logic [2:0] pri_level; // Primary winner
	logic pri_valid; // Primary has a winner
	logic [2:0] sec_level; // Secondary winner
	logic sec_valid; // Secondary has a winner
	logic ack_take; // Acknowledge accepted this cycle
	logic via_cascade; // Winner lies on the secondary
	logic swap; // Accepted setup swap level

	////////////////////////////////////////////////////////////////////
	// Pin packing by position
	always_comb begin
		pin_raw = '0;
		pin_raw[`CIC_PIN_TIMER] = irq_pins.timer_out;
		pin_raw[`CIC_PIN_KBD] = irq_pins.kbd_obf;
		pin_raw[`CIC_PIN_SER_A] = irq_pins.serial_a;
		pin_raw[`CIC_PIN_SER_B] = irq_pins.serial_b;
		pin_raw[`CIC_PIN_FLOPPY] = irq_pins.floppy;
		pin_raw[`CIC_PIN_LPT1] = irq_pins.lpt1;
		pin_raw[`CIC_PIN_RTC] = irq_pins.rtc;
		pin_raw[`CIC_PIN_LAN] = irq_pins.lan;
		pin_raw[`CIC_PIN_SPARE11] = irq_pins.spare11;
		pin_raw[`CIC_PIN_MOUSE] = irq_pins.mouse;
		pin_raw[`CIC_PIN_FPU] = irq_pins.fpu;
		pin_raw[`CIC_PIN_HD0] = irq_pins.hd0;
		pin_raw[`CIC_PIN_HD1] = irq_pins.hd1;
		pin_raw[`CIC_PIN_SWAP] = serial_swap;
	end

	////////////////////////////////////////////////////////////////////
	// Level routing onto the two arbiters
	always_comb begin
		swap = st_r.filt[`CIC_PIN_SWAP];
		pri_req = '0;
		sec_req = '0;
		pri_req[0] = st_r.filt[`CIC_PIN_TIMER];
		// Software may instead poll the keyboard; the line still routes
		pri_req[1] = st_r.filt[`CIC_PIN_KBD];
		pri_req[2] = sec_int;
		// Setup decides which serial port takes which level
		pri_req[3] = swap ? st_r.filt[`CIC_PIN_SER_B]
			: st_r.filt[`CIC_PIN_SER_A];
		pri_req[4] = swap ? st_r.filt[`CIC_PIN_SER_A]
			: st_r.filt[`CIC_PIN_SER_B];
		pri_req[5] = 1'b0;
		pri_req[6] = st_r.filt[`CIC_PIN_FLOPPY];
		pri_req[7] = st_r.filt[`CIC_PIN_LPT1];
		sec_req[0] = st_r.filt[`CIC_PIN_RTC];
		sec_req[1] = 1'b0;
		sec_req[2] = st_r.filt[`CIC_PIN_LAN];
		sec_req[3] = st_r.filt[`CIC_PIN_SPARE11];
		sec_req[4] = st_r.filt[`CIC_PIN_MOUSE];
		sec_req[5] = st_r.filt[`CIC_PIN_FPU];
		sec_req[6] = st_r.filt[`CIC_PIN_HD0];
		sec_req[7] = st_r.filt[`CIC_PIN_HD1];
	end

	////////////////////////////////////////////////////////////////////
	// The two arbiters in cascade
	cic_arbiter u_secondary (
		.clock(clock),
		.rst_n(rst_n),
		.req_in(sec_req),
		.ack(ack_take && via_cascade),
		.eoi(eoi_secondary),
		.int_out(sec_int),
		.win_level(sec_level),
		.win_valid(sec_valid)
	);

	cic_arbiter u_primary (
		.clock(clock),
		.rst_n(rst_n),
		.req_in(pri_req),
		.ack(ack_take),
		.eoi(eoi_primary),
		.int_out(pri_int),
		.win_level(pri_level),
		.win_valid(pri_valid)
	);

	////////////////////////////////////////////////////////////////////
	// Synchronisers, acknowledge and vector answer
	always_comb begin
		st_nxt = st_r;
		// Three stages; the first is only read by the second
		st_nxt.sync1 = pin_raw;
		st_nxt.sync2 = st_r.sync1;
		st_nxt.sync3 = st_r.sync2;
		// Accept a level only when stages two and three agree
		st_nxt.filt = (st_r.sync2 & st_r.sync3)
			| (st_r.filt & (st_r.sync2 | st_r.sync3));
		// An acknowledge with no request out is ignored
		ack_take = intr_ack && st_r.int_req;
		via_cascade = pri_valid && (pri_level == `CIC_CASCADE_LEVEL);
		st_nxt.ans.valid = ack_take;
		if (ack_take) begin
			if (via_cascade) begin
				// Secondary names the level, priority is that of level 2
				st_nxt.ans.vector = SEC_VEC_BASE
					+ {5'h00, sec_level};
			end else begin
				st_nxt.ans.vector = PRI_VEC_BASE
					+ {5'h00, pri_level};
			end
		end
		// Dropped low while the vector is answered, so the processor
		// never sees a stale request in the acknowledge cycle
		st_nxt.int_req = pri_int && !ack_take;
	end

	////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign int_req = st_r.int_req;
	assign vec_out = st_r.ans;

	////////////////////////////////////////////////////////////////////
	// Checks
	property p_vec_after_ack;
		@(posedge clock) disable iff (!rst_n)
		(intr_ack && int_req) |=> vec_out.valid;
	endproperty
	a_vec_after_ack: assert property (p_vec_after_ack)
		else $error("no vector after acknowledge");

	property p_vec_needs_ack;
		@(posedge clock) disable iff (!rst_n)
		vec_out.valid |-> $past(intr_ack && int_req);
	endproperty
	a_vec_needs_ack: assert property (p_vec_needs_ack)
		else $error("vector without acknowledge");

	property p_cascade_vec;
		@(posedge clock) disable iff (!rst_n)
		(ack_take && pri_valid && pri_level == 3'h2)
			|=> vec_out.vector == SEC_VEC_BASE + {5'h00, $past(sec_level)};
	endproperty
	a_cascade_vec: assert property (p_cascade_vec)
		else $error("cascade vector not from secondary");

	property p_timer_route;
		@(posedge clock) disable iff (!rst_n)
		pri_req[0] == st_r.filt[`CIC_PIN_TIMER];
	endproperty
	a_timer_route: assert property (p_timer_route)
		else $error("timer not on level 0");

	property p_cascade_route;
		@(posedge clock) disable iff (!rst_n)
		sec_int |-> ##[0:2] (pri_int || u_primary.st_r.isr != 8'h00);
	endproperty
	a_cascade_route: assert property (p_cascade_route)
		else $error("secondary request not seen on primary");

	property p_serial_swap;
		@(posedge clock) disable iff (!rst_n)
		swap |-> pri_req[3] == st_r.filt[`CIC_PIN_SER_B];
	endproperty
	a_serial_swap: assert property (p_serial_swap)
		else $error("serial swap not applied");

endmodule

// ===== design/cic_pkg.sv
/*
 * Types of the cascaded interrupt controller.
 * Assumes cic_consts.svh is on the include path.
 */
`include "cic_consts.svh"
package cic_pkg;

	// Request pins from the board peripherals
	typedef struct packed {
		logic timer_out; // System timer output
		logic kbd_obf; // Keyboard output buffer full
		logic serial_a; // First serial port
		logic serial_b; // Second serial port
		logic floppy; // Floppy disk adapter
		logic lpt1; // First parallel port
		logic rtc; // Real-time clock
		logic lan; // Network adapter via PCI routing
		logic spare11; // Unassigned level 11
		logic mouse; // Pointing device
		logic fpu; // Math coprocessor
		logic hd0; // First hard disk adapter
		logic hd1; // Second hard disk adapter
	} cic_irq_pins_s;

	// Answer to the processor after an acknowledge
	typedef struct packed {
		logic valid; // One-cycle pulse
		logic [7:0] vector; // Service routine index
	} cic_vec_s;

	// State of one request arbiter
	typedef struct packed {
		logic [7:0] prev; // Request levels seen last cycle
		logic [7:0] irr; // Pending requests
		logic [7:0] isr; // Requests in service
		logic int_r; // Request toward the next stage
	} cic_arb_state_s;

	// State of the top level
	typedef struct packed {
		logic [`CIC_NPIN-1:0] sync1;
		logic [`CIC_NPIN-1:0] sync2;
		logic [`CIC_NPIN-1:0] sync3;
		logic [`CIC_NPIN-1:0] filt; // Accepted pin levels
		logic int_req; // Request to the processor
		cic_vec_s ans; // Vector answer
	} cic_top_state_s;

	// Lowest set bit, i.e. highest priority; 8 when no bit is set
	function automatic logic [3:0] cic_lowest(input logic [7:0] b);
		logic [3:0] r;
		r = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			if (b[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

endpackage

// ===== dv/cic_cpu_model.sv
/*
 * Host processor model: takes a request, acknowledges it, reads the
 * vector in its one valid cycle and ends the interrupt.
 * Assumes the controller's answer is registered on the same clock.
 */
`timescale 1ns/1ns
module cic_cpu_model
	import cic_pkg::*;
#(
	parameter logic [7:0] SEC_VEC_BASE = 8'h70
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic en, // Service enable
	input wire logic [3:0] ack_delay, // Idle cycles before acknowledge
	input wire logic int_req,
	input cic_vec_s vec_out,
	output logic intr_ack,
	output logic eoi_primary,
	output logic eoi_secondary,
	output logic got, // One cycle when a vector was read
	output logic [7:0] vec_seen // Last vector read
);
	logic sec; // Vector belongs to the secondary
	// Quiet outputs at time zero
	initial begin
		intr_ack = 1'b0;
		eoi_primary = 1'b0;
		eoi_secondary = 1'b0;
		got = 1'b0;
		vec_seen = 8'h00;
	end
	////////////////////////////////////////////////////////////////////
	// Service loop; one interrupt at a time, no nesting
	always begin
		@(posedge clock);
		if (rst_n && en && int_req) begin
			repeat (ack_delay) @(posedge clock);
			intr_ack <= 1'b1;
			@(posedge clock);
			intr_ack <= 1'b0;
			@(posedge clock);
			// Read only in the valid cycle; a late read gets nothing
			sec = vec_out.vector[7:3] == SEC_VEC_BASE[7:3];
			vec_seen <= vec_out.valid ? vec_out.vector : 8'h00;
			got <= 1'b1;
			eoi_primary <= 1'b1;
			eoi_secondary <= sec;
			@(posedge clock);
			got <= 1'b0;
			eoi_primary <= 1'b0;
			eoi_secondary <= 1'b0;
		end
	end
endmodule

// ===== dv/tb_top.sv
/*
 * Testbench of the cascaded interrupt controller with a host model.
 * Assumes the design answers an acknowledge within a few cycles.
 */
`timescale 1ns/1ns
module tb_top;
	import cic_pkg::*;
	localparam logic [7:0] PB = 8'h08; // Primary vector base
	localparam logic [7:0] SB = 8'h70; // Secondary vector base
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	cic_irq_pins_s irq_pins = '0; // Pins, timer_out is bit 12
	logic serial_swap = 1'b0;
	logic en = 1'b0; // Host services requests
	logic [3:0] ack_delay = 4'h0;
	logic intr_ack, eoi_primary, eoi_secondary, int_req, got;
	logic [7:0] vec_seen;
	cic_vec_s vec_out;
	int mismatches = 0;
	int cmp_count = 0;
	// Level of each pin in field order
	int lvl[13] = '{0, 1, 3, 4, 6, 7, 8, 10, 11, 12, 13, 14, 15};
	// 10 MHz clock
	always #50 clock = ~clock;
	cic_controller #(.PRI_VEC_BASE(PB), .SEC_VEC_BASE(SB)) u_cic_controller (
		.clock(clock), .rst_n(rst_n), .irq_pins(irq_pins),
		.serial_swap(serial_swap), .intr_ack(intr_ack),
		.eoi_primary(eoi_primary), .eoi_secondary(eoi_secondary),
		.int_req(int_req), .vec_out(vec_out));
	cic_cpu_model #(.SEC_VEC_BASE(SB)) u_cic_cpu_model (
		.clock(clock), .rst_n(rst_n), .en(en), .ack_delay(ack_delay),
		.int_req(int_req), .vec_out(vec_out), .intr_ack(intr_ack),
		.eoi_primary(eoi_primary), .eoi_secondary(eoi_secondary),
		.got(got), .vec_seen(vec_seen));
	////////////////////////////////////////////////////////////////////
	// Compare and count
	task check(input string what, input logic [8:0] seen,
		input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Verdict and end of run
	task test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Expected vector of a pin index
	function automatic logic [7:0] exp_vec(input int i);
		return lvl[i] < 8 ? PB + 8'(lvl[i]) : SB + 8'(lvl[i] - 8);
	endfunction
	// Wait, bounded, for the host to read a vector, then judge it
	task wait_vec(input logic [7:0] exp);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (got !== 1'b1 && n < 100);
		// A host that never got its vector counts as a mismatch
		check("got", {8'h00, got}, 9'h001);
		check("vector", {1'b0, vec_seen}, {1'b0, exp});
	endtask
	////////////////////////////////////////////////////////////////////
	// Every pin alone, host at varied speed
	task t_levels();
		for (int i = 0; i < 13; i++) begin
			@(posedge clock);
			ack_delay <= 4'(i % 4);
			irq_pins[12 - i] <= 1'b1;
			wait_vec(exp_vec(i));
			irq_pins[12 - i] <= 1'b0;
			repeat (6) @(posedge clock);
		end
	endtask
	// Setup swap moves the serial ports between levels 3 and 4
	task t_swap();
		serial_swap <= 1'b1;
		repeat (6) @(posedge clock);
		irq_pins.serial_a <= 1'b1;
		wait_vec(PB + 8'h04);
		irq_pins.serial_a <= 1'b0;
		irq_pins.serial_b <= 1'b1;
		wait_vec(PB + 8'h03);
		irq_pins.serial_b <= 1'b0;
		serial_swap <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
	// Three requests at once; cascade rides level 2 between 0 and 7
	task t_priority();
		en <= 1'b0;
		irq_pins.timer_out <= 1'b1;
		irq_pins.hd1 <= 1'b1;
		irq_pins.lpt1 <= 1'b1;
		repeat (12) @(posedge clock);
		check("int_req", {8'h00, int_req}, 9'h001);
		check("valid", {8'h00, vec_out.valid}, 9'h000);
		en <= 1'b1;
		ack_delay <= 4'h3;
		wait_vec(PB);
		wait_vec(SB + 8'h07);
		wait_vec(PB + 8'h07);
		irq_pins <= '0;
		repeat (6) @(posedge clock);
	endtask
	// A request that falls before any acknowledge is dropped
	task t_withdrawn();
		en <= 1'b0;
		irq_pins.kbd_obf <= 1'b1;
		repeat (8) @(posedge clock);
		check("int_req", {8'h00, int_req}, 9'h001);
		irq_pins.kbd_obf <= 1'b0;
		repeat (8) @(posedge clock);
		check("int_req", {8'h00, int_req}, 9'h000);
		en <= 1'b1;
	endtask
	// Reset in mid-run with a pin held high: seen again as a new edge
	task t_reset();
		@(posedge clock);
		en <= 1'b0;
		irq_pins.timer_out <= 1'b1;
		repeat (8) @(posedge clock);
		check("int_req", {8'h00, int_req}, 9'h001);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		check("int_req", {8'h00, int_req}, 9'h000);
		rst_n <= 1'b1;
		@(posedge clock);
		check("int_req", {8'h00, int_req}, 9'h000);
		check("valid", {8'h00, vec_out.valid}, 9'h000);
		repeat (10) @(posedge clock);
		check("int_req", {8'h00, int_req}, 9'h001);
		en <= 1'b1;
		wait_vec(PB);
		irq_pins.timer_out <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
	////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		check("reset int_req", {8'h00, int_req}, 9'h000);
		check("reset vec_out", vec_out, 9'h000);
		en <= 1'b1;
		t_levels();
		t_swap();
		t_priority();
		t_withdrawn();
		t_reset();
		test_done();
	end
	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		test_done();
	end
endmodule
